//--- design/bus_trace_debug_pkg.sv
// Purpose: Shared constants and types of the bus trace debug unit
// Assumes: Byte-wide register port, nine debug bytes plus force-reset byte
// Notes:   Offsets are register indices on the byte register port
package bus_trace_debug_pkg;

  // Register offsets
  localparam logic [3:0] CMP_A_HIGH_OFS      = 4'h0;
  localparam logic [3:0] CMP_A_LOW_OFS       = 4'h1;
  localparam logic [3:0] CMP_B_HIGH_OFS      = 4'h2;
  localparam logic [3:0] CMP_B_LOW_OFS       = 4'h3;
  localparam logic [3:0] TRACE_FIFO_HIGH_OFS = 4'h4;
  localparam logic [3:0] TRACE_FIFO_LOW_OFS  = 4'h5;
  localparam logic [3:0] DEBUG_CONTROL_OFS   = 4'h6;
  localparam logic [3:0] TRIGGER_OFS         = 4'h7;
  localparam logic [3:0] STATUS_OFS          = 4'h8;
  localparam logic [3:0] FORCE_RESET_OFS     = 4'h9;

  // Control register fields
  localparam int CTL_MODULE_ENABLE_BIT = 7;
  localparam int CTL_ARM_BIT           = 6;
  localparam int CTL_TAG_BIT           = 5;
  localparam int CTL_BREAK_ENABLE_BIT  = 4;
  localparam int CTL_A_DIR_VALUE_BIT   = 3;
  localparam int CTL_A_DIR_QUAL_BIT    = 2;
  localparam int CTL_B_DIR_VALUE_BIT   = 1;
  localparam int CTL_B_DIR_QUAL_BIT    = 0;

  // Trigger register fields
  localparam int TRG_EXEC_QUALIFY_BIT  = 7;
  localparam int TRG_BEGIN_BIT         = 6;
  localparam int TRG_MODE_MSB          = 3;

  // Status register fields
  localparam int STS_A_FLAG_BIT        = 7;
  localparam int STS_B_FLAG_BIT        = 6;
  localparam int STS_RUN_ACTIVE_BIT    = 5;

  // Force-reset register field
  localparam int FORCE_RESET_BIT       = 0;

  // Reset values
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Trace buffer shape
  localparam int TRACE_DEPTH           = 8;
  localparam int TRACE_WIDTH           = 16;
  localparam int BUS_ADDR_WIDTH        = 16;

  typedef enum logic [3:0] {
    MODE_A_ONLY      = 4'h0,
    MODE_A_OR_B      = 4'h1,
    MODE_A_THEN_B    = 4'h2,
    MODE_EVENT_B     = 4'h3,
    MODE_A_EVENT_B   = 4'h4,
    MODE_A_AND_DATA  = 4'h5,
    MODE_A_NOT_DATA  = 4'h6,
    MODE_INSIDE      = 4'h7,
    MODE_OUTSIDE     = 4'h8
  } trig_mode_type;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_PRE   = 2'b01,
    RUN_POST  = 2'b10
  } run_state_type;

endpackage : bus_trace_debug_pkg

//--- design/bus_trace_debug_module.sv
// Purpose: Bus trace debug unit with comparators, capture FIFO and force reset
// Assumes: All inputs synchronous to clk; strobes are one-cycle pulses
// Notes:   Behaviour notes stand beside the logic they describe
`timescale 1ns/100ps

module trace_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH+1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("trace_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;
  logic             full;

  assign full      = (count_q == FULL_CNT);
  // Full still accepts when the head leaves in the same cycle
  assign in_ready  = !full || out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_ptr_q];
  assign count     = count_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : trace_fifo

module bus_trace_debug_module
  import bus_trace_debug_pkg::*;
#(
  parameter int ADDR_W = BUS_ADDR_WIDTH,
  parameter int DEPTH  = TRACE_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              bdm_wr,
  input  wire logic [3:0]        bdm_addr,
  input  wire logic [7:0]        bdm_wdata,
  input  wire logic              mcu_secure,
  input  wire logic              bus_valid,
  input  wire logic              bus_rw,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]        bus_data,
  input  wire logic              opcode_fetch,
  input  wire logic              cof_valid,
  input  wire logic              exec_valid,
  input  wire logic [ADDR_W-1:0] exec_addr,
  output logic                   break_req,
  output logic                   break_tag,
  output logic                   sys_reset_req,
  output logic                   run_active
);
  localparam int CNT_W = $clog2(DEPTH+1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  initial begin
    if (ADDR_W != 2 * 8) begin
      $error("comparators are two bytes wide, address width must be 16");
    end
    if (DEPTH < 2 || DEPTH > 15) begin
      $error("trace depth must fit the four-bit valid count");
    end
  end

  // Register state
  logic [7:0]          cmp_a_high_q;
  logic [7:0]          cmp_a_low_q;
  logic [7:0]          cmp_b_high_q;
  logic [7:0]          cmp_b_low_q;
  logic [7:0]          control_q;
  logic [7:0]          trigger_q;
  logic [7:0]          reg_rdata_q;
  logic                break_req_q;
  logic                break_tag_q;
  logic                sys_reset_q;
  logic                a_flag_q;
  logic                b_flag_q;
  logic                seen_a_q;
  logic [CNT_W-1:0]    valid_cnt_q;
  logic [ADDR_W-1:0]   last_opcode_q;
  run_state_type       run_state_q;

  // Decoded controls
  logic                module_enable;
  logic                armed;
  logic                break_request_enable;
  logic                exec_qualify_select;
  logic                begin_select;
  logic                event_mode;
  logic                begin_trace;
  logic [3:0]          trigger_mode_field;
  logic [ADDR_W-1:0]   cmp_a;
  logic [ADDR_W-1:0]   cmp_b;

  // Comparator path
  logic                src_valid;
  logic                src_rw;
  logic [ADDR_W-1:0]   src_addr;
  logic                dir_ok_a;
  logic                dir_ok_b;
  logic                hit_a;
  logic                hit_b;
  logic                trig_event;

  // Register port decode
  logic                ctl_write;
  logic                arm_write_set;
  logic                arm_write_clr;
  logic                cmp_write_ok;
  logic                low_read;

  // FIFO connection
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic [TRACE_WIDTH-1:0] fifo_in_data;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [TRACE_WIDTH-1:0] fifo_out_data;
  logic [CNT_W-1:0]    fifo_count;
  logic                fifo_full;
  logic                run_start;
  logic                run_done;
  logic                store_cof;
  logic                store_event;

  assign module_enable        = control_q[CTL_MODULE_ENABLE_BIT];
  assign armed                = (run_state_q != RUN_IDLE);
  assign break_request_enable = control_q[CTL_BREAK_ENABLE_BIT];
  assign exec_qualify_select  = trigger_q[TRG_EXEC_QUALIFY_BIT];
  assign begin_select         = trigger_q[TRG_BEGIN_BIT];
  assign trigger_mode_field   = trigger_q[TRG_MODE_MSB:0];
  assign cmp_a                = {cmp_a_high_q, cmp_a_low_q};
  assign cmp_b                = {cmp_b_high_q, cmp_b_low_q};
  assign event_mode           = (trigger_mode_field == MODE_EVENT_B)
                             || (trigger_mode_field == MODE_A_EVENT_B);
  // Event-only runs are always begin traces
  assign begin_trace          = begin_select || event_mode;

  // Exec qualification only swaps the match source; the run logic is shared
  assign src_valid = exec_qualify_select ? exec_valid : bus_valid;
  assign src_rw    = exec_qualify_select ? 1'b1 : bus_rw;
  assign src_addr  = exec_qualify_select ? exec_addr : bus_addr;

  assign dir_ok_a = !control_q[CTL_A_DIR_QUAL_BIT]
                 || (src_rw == control_q[CTL_A_DIR_VALUE_BIT]);
  assign dir_ok_b = !control_q[CTL_B_DIR_QUAL_BIT]
                 || (src_rw == control_q[CTL_B_DIR_VALUE_BIT]);

  assign hit_a = armed && src_valid && dir_ok_a && (src_addr == cmp_a);
  assign hit_b = armed && src_valid && dir_ok_b && (src_addr == cmp_b);

  always_comb begin
    trig_event = 1'b0;
    unique case (trigger_mode_field)
      MODE_A_ONLY:     trig_event = hit_a;
      MODE_A_OR_B:     trig_event = hit_a || hit_b;
      MODE_A_THEN_B:   trig_event = hit_b && seen_a_q;
      MODE_EVENT_B:    trig_event = hit_b;
      MODE_A_EVENT_B:  trig_event = hit_b && seen_a_q;
      MODE_A_AND_DATA: trig_event = hit_a && (bus_data == cmp_b_low_q);
      MODE_A_NOT_DATA: trig_event = hit_a && (bus_data != cmp_b_low_q);
      MODE_INSIDE:     trig_event = armed && src_valid && dir_ok_a
                                 && (src_addr >= cmp_a) && (src_addr <= cmp_b);
      MODE_OUTSIDE:    trig_event = armed && src_valid && dir_ok_a
                                 && ((src_addr < cmp_a) || (src_addr > cmp_b));
      default:         trig_event = 1'b0;
    endcase
  end

  // Register port strobes
  assign ctl_write     = reg_wr && (reg_addr == DEBUG_CONTROL_OFS);
  assign arm_write_set = ctl_write && reg_wdata[CTL_ARM_BIT]
                      && reg_wdata[CTL_MODULE_ENABLE_BIT] && !mcu_secure;
  assign arm_write_clr = ctl_write && !arm_write_set;
  assign cmp_write_ok  = reg_wr && !armed;
  assign low_read      = reg_rd && (reg_addr == TRACE_FIFO_LOW_OFS);
  assign run_start     = arm_write_set;

  assign fifo_full = (fifo_count == FULL_CNT);

  // Capture sources: change-of-flow addresses or event bytes
  assign store_event = (run_state_q == RUN_PRE) && event_mode && trig_event;
  assign store_cof   = cof_valid && !event_mode
                    && (((run_state_q == RUN_PRE) && !begin_trace)
                     || (run_state_q == RUN_POST));

  always_comb begin
    fifo_in_valid  = 1'b0;
    fifo_in_data   = '0;
    fifo_out_ready = 1'b0;
    if (armed) begin
      if (store_event) begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = {8'h00, bus_data};
      end else if (store_cof) begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = bus_addr;
        // End trace is circular: the oldest word falls out
        fifo_out_ready = !begin_trace && fifo_full;
      end
      // Reads never shift the buffer while armed
    end else if (low_read) begin
      fifo_in_valid  = 1'b1;
      fifo_in_data   = last_opcode_q;
      // Pops only once full, so the buffer acts as an eight-word delay line
      fifo_out_ready = fifo_full;
    end
  end

  trace_fifo #(
    .WIDTH (TRACE_WIDTH),
    .DEPTH (DEPTH)
  ) u_trace_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (run_start),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  // Begin traces end on full; end traces end on the trigger itself
  always_comb begin
    run_done = 1'b0;
    if (run_state_q == RUN_PRE && !begin_trace) begin
      run_done = trig_event;
    end else if (armed && begin_trace) begin
      run_done = fifo_full || (fifo_in_valid && !fifo_in_ready);
    end
  end

  // Run sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_state_q <= RUN_IDLE;
    end else if (run_start) begin
      run_state_q <= RUN_PRE;
    end else if (arm_write_clr || !module_enable || run_done) begin
      run_state_q <= RUN_IDLE;
    end else begin
      unique case (run_state_q)
        RUN_IDLE: run_state_q <= RUN_IDLE;
        RUN_PRE: begin
          if (begin_trace && !event_mode && trig_event) begin
            run_state_q <= RUN_POST;
          end
        end
        RUN_POST: run_state_q <= RUN_POST;
        default:  run_state_q <= RUN_IDLE;
      endcase
    end
  end

  // Control register; arm bit mirrors the run state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET;
    end else if (ctl_write) begin
      control_q <= reg_wdata;
      control_q[CTL_MODULE_ENABLE_BIT] <= reg_wdata[CTL_MODULE_ENABLE_BIT]
                                        && !mcu_secure;
      control_q[CTL_ARM_BIT] <= arm_write_set;
    end else begin
      control_q[CTL_ARM_BIT] <= armed && !run_done && module_enable;
    end
  end

  // Comparator and trigger registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_a_high_q <= CMP_RESET;
      cmp_a_low_q  <= CMP_RESET;
      cmp_b_high_q <= CMP_RESET;
      cmp_b_low_q  <= CMP_RESET;
      trigger_q    <= TRIGGER_RESET;
    end else if (cmp_write_ok) begin
      unique case (reg_addr)
        CMP_A_HIGH_OFS: cmp_a_high_q <= reg_wdata;
        CMP_A_LOW_OFS:  cmp_a_low_q  <= reg_wdata;
        CMP_B_HIGH_OFS: cmp_b_high_q <= reg_wdata;
        CMP_B_LOW_OFS:  cmp_b_low_q  <= reg_wdata;
        TRIGGER_OFS:    trigger_q    <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]};
        default: begin
        end
      endcase
    end
  end

  // Match flags and sequence memory, cleared at each run start
  always_ff @(posedge clk) begin
    if (!rst_n || run_start) begin
      a_flag_q <= 1'b0;
      b_flag_q <= 1'b0;
      seen_a_q <= 1'b0;
    end else begin
      if (hit_a) begin
        a_flag_q <= 1'b1;
        seen_a_q <= 1'b1;
      end
      if (hit_b) begin
        b_flag_q <= 1'b1;
      end
    end
  end

  // Valid count freezes once the run ends
  always_ff @(posedge clk) begin
    if (!rst_n || run_start) begin
      valid_cnt_q <= '0;
    end else if (armed) begin
      valid_cnt_q <= fifo_count + CNT_W'(fifo_in_valid && fifo_in_ready
                                         && !fifo_out_ready);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_opcode_q <= '0;
    end else if (opcode_fetch) begin
      last_opcode_q <= bus_addr;
    end
  end

  // Break request: one pulse per completed run
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      break_req_q <= 1'b0;
      break_tag_q <= 1'b0;
    end else begin
      break_req_q <= run_done && break_request_enable && !run_start;
      if (run_done && break_request_enable) begin
        break_tag_q <= control_q[CTL_TAG_BIT];
      end
    end
  end

  // Force reset only through the serial debug write path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_reset_q <= 1'b0;
    end else begin
      sys_reset_q <= bdm_wr && (bdm_addr == FORCE_RESET_OFS)
                  && bdm_wdata[FORCE_RESET_BIT];
    end
  end

  // Read data; unmapped and write-only bytes read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= READ_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CMP_A_HIGH_OFS:      reg_rdata_q <= cmp_a_high_q;
        CMP_A_LOW_OFS:       reg_rdata_q <= cmp_a_low_q;
        CMP_B_HIGH_OFS:      reg_rdata_q <= cmp_b_high_q;
        CMP_B_LOW_OFS:       reg_rdata_q <= cmp_b_low_q;
        TRACE_FIFO_HIGH_OFS: reg_rdata_q <= (event_mode || !fifo_out_valid)
                                          ? READ_ZERO : fifo_out_data[15:8];
        TRACE_FIFO_LOW_OFS:  reg_rdata_q <= fifo_out_valid
                                          ? fifo_out_data[7:0] : READ_ZERO;
        DEBUG_CONTROL_OFS:   reg_rdata_q <= control_q;
        TRIGGER_OFS:         reg_rdata_q <= trigger_q;
        STATUS_OFS:          reg_rdata_q <= {a_flag_q, b_flag_q, armed, 1'b0,
                                             valid_cnt_q};
        FORCE_RESET_OFS:     reg_rdata_q <= READ_ZERO;
        default:             reg_rdata_q <= READ_ZERO;
      endcase
    end
  end

  assign reg_rdata     = reg_rdata_q;
  assign break_req     = break_req_q;
  assign break_tag     = break_tag_q;
  assign sys_reset_req = sys_reset_q;
  assign run_active    = control_q[CTL_ARM_BIT];

endmodule : bus_trace_debug_module

//--- tb/bus_trace_debug_monitor.sv
// Purpose: Port assertions for the bus trace debug unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the unit
`timescale 1ns/100ps
module bus_trace_debug_monitor
  import bus_trace_debug_pkg::*;
#(
  parameter int ADDR_W = BUS_ADDR_WIDTH,
  parameter int DEPTH  = TRACE_DEPTH
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       bdm_wr,
  input wire logic [3:0] bdm_addr,
  input wire logic [7:0] bdm_wdata,
  input wire logic       mcu_secure,
  input wire logic       break_req,
  input wire logic       sys_reset_req,
  input wire logic       run_active
);
  logic host_rst;
  logic ctl_wr;
  assign host_rst = bdm_wr && bdm_addr == FORCE_RESET_OFS && bdm_wdata[FORCE_RESET_BIT];
  assign ctl_wr   = reg_wr && reg_addr == DEBUG_CONTROL_OFS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_host_reset_req: assert property (host_rst |=> sys_reset_req)
    else $error("host force reset not requested");
  a_no_cpu_reset: assert property (!host_rst |=> !sys_reset_req)
    else $error("reset request without host write");
  a_reset_reg_zero: assert property (reg_rd && reg_addr == FORCE_RESET_OFS |=> reg_rdata == 8'h00)
    else $error("force reset register read nonzero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > FORCE_RESET_OFS |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_arm_sets_run: assert property (ctl_wr && reg_wdata[7:6] == 2'b11 && !mcu_secure |=> run_active)
    else $error("arm write did not start run");
  a_disarm_stops: assert property (ctl_wr && reg_wdata[7:6] != 2'b11 |=> !run_active)
    else $error("disarm write did not stop run");
  a_break_run_end: assert property (break_req |-> !run_active && $past(run_active))
    else $error("break outside run end");
  a_break_pulse: assert property (break_req |=> !break_req)
    else $error("break request longer than one cycle");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  c_arm: cover property (ctl_wr ##1 run_active);
  c_break: cover property (break_req);
  c_host_reset: cover property (sys_reset_req);
endmodule : bus_trace_debug_monitor

bind bus_trace_debug_module bus_trace_debug_monitor #(
  .ADDR_W(ADDR_W),
  .DEPTH (DEPTH)
) bus_trace_debug_monitor_i (
  .clk          (clk),
  .rst_n        (rst_n),
  .reg_addr     (reg_addr),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_wdata    (reg_wdata),
  .reg_rdata    (reg_rdata),
  .bdm_wr       (bdm_wr),
  .bdm_addr     (bdm_addr),
  .bdm_wdata    (bdm_wdata),
  .mcu_secure   (mcu_secure),
  .break_req    (break_req),
  .sys_reset_req(sys_reset_req),
  .run_active   (run_active)
);

//--- tb/cpu_bus_model.sv
// Purpose: CPU bus and serial debug host model
// Assumes: Drives just after rising edges, holds one cycle
// Notes:   Released lines show inverted last values
`timescale 1ns/100ps
module cpu_bus_model (
  input  wire logic  clk,
  output logic       bus_valid,
  output logic       bus_rw,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_data,
  output logic       opcode_fetch,
  output logic       cof_valid,
  output logic       exec_valid,
  output logic [15:0] exec_addr,
  output logic       bdm_wr,
  output logic [3:0] bdm_addr,
  output logic [7:0] bdm_wdata
);
  initial begin
    {bus_valid, bus_rw, opcode_fetch, cof_valid, exec_valid, bdm_wr} = 6'h00;
    {bus_addr, exec_addr, bus_data} = 40'h0;
    {bdm_addr, bdm_wdata} = 12'h000;
  end

  // Kind 1 opcode fetch, 2 change of flow, else plain cycle
  task automatic cycle(input logic rw, input logic [15:0] a, input logic [7:0] d, input int kind);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_rw <= rw;
    bus_addr <= a;
    bus_data <= d;
    exec_addr <= a;
    opcode_fetch <= (kind == 1);
    exec_valid <= (kind == 1);
    cof_valid <= (kind == 2);
    @(posedge clk);
    {bus_valid, opcode_fetch, exec_valid, cof_valid} <= 4'h0;
    bus_addr <= ~a;
    exec_addr <= ~a;
    bus_data <= ~d;
    #1;
  endtask : cycle

  // Serial background write, the only path to the force-reset bit
  task automatic host_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bdm_wr <= 1'b1;
    bdm_addr <= a;
    bdm_wdata <= d;
    @(posedge clk);
    bdm_wr <= 1'b0;
    bdm_addr <= ~a;
    bdm_wdata <= ~d;
  endtask : host_write
endmodule : cpu_bus_model

//--- tb/bus_trace_debug_module_tb.sv
// Purpose: Register-level tests of the bus trace debug unit
// Assumes: Register port answers one cycle after the read edge
// Notes:   Break and reset pulses are counted, not sampled
`timescale 1ns/100ps
module bus_trace_debug_module_tb;
  import bus_trace_debug_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, mcu_secure, run_active;
  logic [3:0] reg_addr, bdm_addr;
  logic [7:0] reg_wdata, reg_rdata, bus_data, bdm_wdata, v;
  logic [15:0] bus_addr, exec_addr;
  logic bus_valid, bus_rw, opcode_fetch, cof_valid, exec_valid;
  logic bdm_wr, break_req, break_tag, sys_reset_req;
  int num_errors, n_checks, n_break, n_rst;

  always #10 clk = ~clk;

  bus_trace_debug_module bus_trace_debug_module_i (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bdm_wr(bdm_wr), .bdm_addr(bdm_addr), .bdm_wdata(bdm_wdata),
    .mcu_secure(mcu_secure), .bus_valid(bus_valid), .bus_rw(bus_rw), .bus_addr(bus_addr),
    .bus_data(bus_data), .opcode_fetch(opcode_fetch), .cof_valid(cof_valid),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .break_req(break_req),
    .break_tag(break_tag), .sys_reset_req(sys_reset_req), .run_active(run_active));

  cpu_bus_model cpu_bus_model_i (.clk(clk), .bus_valid(bus_valid), .bus_rw(bus_rw),
    .bus_addr(bus_addr), .bus_data(bus_data), .opcode_fetch(opcode_fetch),
    .cof_valid(cof_valid), .exec_valid(exec_valid), .exec_addr(exec_addr),
    .bdm_wr(bdm_wr), .bdm_addr(bdm_addr), .bdm_wdata(bdm_wdata));

  always @(posedge clk) begin
    if (break_req === 1'b1) n_break <= n_break + 1;
    if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rdc

  // High byte first, since the low read moves the buffer on
  task automatic word(input logic [15:0] e);
    logic [7:0] hi, lo;
    rd(TRACE_FIFO_HIGH_OFS, hi);
    rd(TRACE_FIFO_LOW_OFS, lo);
    chk("fifo_word", e, {hi, lo});
  endtask : word

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    {clk, rst_n, reg_wr, reg_rd, mcu_secure} = 5'h0;
    {reg_addr, reg_wdata} = 12'h000;
    {num_errors, n_checks, n_break, n_rst} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      if (a != 4 && a != 5) rdc("reset_value", a[3:0], 8'h00);
    end
    for (int a = 0; a < 4; a++) begin
      wr(a[3:0], 8'h5A ^ a[7:0]);
      rdc("cmp_rw", a[3:0], 8'h5A ^ a[7:0]);
    end
    wr(FORCE_RESET_OFS, 8'h01);
    wr(TRACE_FIFO_HIGH_OFS, 8'hFF);
    rdc("force_reset_read", FORCE_RESET_OFS, 8'h00);
    rdc("unmapped_read", 4'hC, 8'h00);
    chk("cpu_reset_count", 16'h0, n_rst[15:0]);
    cpu_bus_model_i.host_write(FORCE_RESET_OFS, 8'h01);
    settle(2);
    chk("host_reset_count", 16'h1, n_rst[15:0]);
    mcu_secure <= 1'b1;
    wr(DEBUG_CONTROL_OFS, 8'h80);
    rdc("secure_enable", DEBUG_CONTROL_OFS, 8'h00);
    mcu_secure <= 1'b0;
    // End trace on A, read cycles only, tag break
    wr(CMP_A_HIGH_OFS, 8'h12);
    wr(CMP_A_LOW_OFS, 8'h34);
    wr(TRIGGER_OFS, 8'h00);
    wr(DEBUG_CONTROL_OFS, 8'hFC);
    wr(CMP_A_HIGH_OFS, 8'hEE);
    rdc("cmp_locked", CMP_A_HIGH_OFS, 8'h12);
    rdc("control_armed", DEBUG_CONTROL_OFS, 8'hFC);
    rdc("status_armed", STATUS_OFS, 8'h20);
    cpu_bus_model_i.cycle(1'b0, 16'h1234, 8'h00, 0);
    chk("a_write_ignored", 16'h1, run_active);
    cpu_bus_model_i.cycle(1'b1, 16'h1234, 8'h00, 0);
    settle(1);
    chk("a_read_trigger", 16'h0, run_active);
    chk("break_count", 16'h1, n_break[15:0]);
    chk("break_tag", 16'h1, break_tag);
    rdc("arm_cleared", DEBUG_CONTROL_OFS, 8'hBC);
    // B on write cycles only, no break
    wr(CMP_B_HIGH_OFS, 8'h43);
    wr(CMP_B_LOW_OFS, 8'h21);
    wr(TRIGGER_OFS, 8'h01);
    wr(DEBUG_CONTROL_OFS, 8'hC1);
    cpu_bus_model_i.cycle(1'b1, 16'h4321, 8'h00, 0);
    chk("b_read_ignored", 16'h1, run_active);
    cpu_bus_model_i.cycle(1'b0, 16'h4321, 8'h00, 0);
    settle(1);
    chk("b_write_trigger", 16'h0, run_active);
    chk("no_break_count", 16'h1, n_break[15:0]);
    wr(DEBUG_CONTROL_OFS, 8'hC0);
    wr(DEBUG_CONTROL_OFS, 8'h80);
    settle(1);
    chk("manual_stop", 16'h0, run_active);
    // Begin trace: store eight flow changes after A, then break
    wr(TRIGGER_OFS, 8'h40);
    wr(DEBUG_CONTROL_OFS, 8'hD0);
    cpu_bus_model_i.cycle(1'b1, 16'h1234, 8'h00, 0);
    for (int i = 0; i < 8; i++) cpu_bus_model_i.cycle(1'b1, 16'h1000 + 16'(i), 8'h00, 2);
    settle(4);
    chk("begin_full_end", 16'h0, run_active);
    chk("begin_break", 16'h2, n_break[15:0]);
    cpu_bus_model_i.cycle(1'b1, 16'h2000, 8'h00, 1);
    rdc("high_no_shift", TRACE_FIFO_HIGH_OFS, 8'h10);
    for (int i = 0; i < 8; i++) word(16'h1000 + 16'(i));
    // Profiling: ninth read returns the first read's opcode address
    for (int i = 0; i < 9; i++) begin
      cpu_bus_model_i.cycle(1'b1, 16'h3000 + 16'(i), 8'h00, 1);
      word((i < 8) ? 16'h2000 : 16'h3000);
    end
    // Event-only B: bytes only, armed read must not shift
    wr(CMP_B_HIGH_OFS, 8'h55);
    wr(CMP_B_LOW_OFS, 8'h55);
    wr(TRIGGER_OFS, 8'h03);
    wr(DEBUG_CONTROL_OFS, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      cpu_bus_model_i.cycle(1'b0, 16'h5555, 8'hA1 + 8'(i), 0);
      if (i == 2) rd(TRACE_FIFO_LOW_OFS, v);
    end
    settle(4);
    chk("armed_read_head", 16'h00A1, {8'h00, v});
    chk("event_run_end", 16'h0, run_active);
    rdc("event_high", TRACE_FIFO_HIGH_OFS, 8'h00);
    for (int i = 0; i < 8; i++) rdc("event_byte", TRACE_FIFO_LOW_OFS, 8'hA1 + 8'(i));
    stop_test();
  end
endmodule : bus_trace_debug_module_tb
